// ### src/simd_math_defines.svh
// constants for the packed simd math datapath: latencies, masks, widths
// assumes inclusion by both design files of the datapath
`ifndef SIMD_MATH_DEFINES_SVH
`define SIMD_MATH_DEFINES_SVH

// ----------------------------------------------------------------
// latencies in core clock cycles
// ----------------------------------------------------------------
`define LAT_XOR 4'h2
`define LAT_MULTIPLY_PIPE 4'h4
`define LAT_DEFAULT 4'h2
`define LAT_RSQRT_APPROX 4'h3
`define LAT_REFINE 4'h4
`define PEN_BYPASS_IN 4'h1
`define PEN_TO_FLOAT 4'h1

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define SIGN_MASK 64'h8000_0000_8000_0000
`define HI_MSB 63
`define HI_LSB 32
`define LO_MSB 31
`define LO_LSB 0
`define FP_ONE_HALF_EXP 8'h7e
`define FP_BIAS 8'h7f
// rsqrt seed: one and a half biases in the exponent field, so subtracting
// half the operand's bit pattern halves and negates its exponent
`define RSQ_SEED_K 32'h5f40_0000
`define RSQ_TABLE_BITS 8

`endif

// ### src/simd_math_pkg.sv
// types shared by the packed simd math datapath
// assumes a single core clock domain
`default_nettype none

package simd_math_pkg;

	// operations issued by the decoder
	typedef enum logic [3:0]
	{
		OP_DWORD_HALF_SWAP,
		OP_PACKED_WORD_MUL_ADD,
		OP_RSQRT_APPROX,
		OP_RSQRT_REFINE_STEP,
		OP_RECIPROCAL_FINAL_STEP,
		OP_PACKED_FLOAT_MULTIPLY,
		OP_PACKED_BITWISE_XOR,
		OP_PACKED_WORD_TO_FLOAT,
		OP_LOW_DWORD_INTERLEAVE,
		OP_REG_COPY
	} simd_op_e;

	// issue pipe choice
	typedef enum logic {PIPE_ADD, PIPE_MUL} pipe_sel_e;

	// issued operation bundle
	typedef struct packed
	{
		simd_op_e op;
		pipe_sel_e pipe;
		logic to_float;
		logic [2:0] dst_tag;
		logic [63:0] dst;
		logic [63:0] src;
	} simd_issue_s;

	// retired result bundle
	typedef struct packed
	{
		logic [2:0] dst_tag;
		logic [63:0] data;
	} simd_result_s;

endpackage : simd_math_pkg

`default_nettype wire

// ### src/simd_lane_unit.sv
// one 32-bit lane of the float helpers: rsqrt estimate, refine, multiply
// assumes ieee single operands, flushes denormals to zero
`default_nettype none
`include "simd_math_defines.svh"

module simd_lane_unit
	import simd_math_pkg::*;
(
	// operands
	input wire logic [31:0] i_a,
	input wire logic [31:0] i_b,
	// results
	output logic [31:0] o_mul,
	output logic [31:0] o_rsqrt,
	output logic [31:0] o_refine,
	output logic [31:0] o_final
);

	// ----------------------------------------------------------------
	// single precision multiply, truncated, no rounding refinement
	// ----------------------------------------------------------------
	function automatic logic [31:0] multiply_pipe(input logic [31:0] x,
		input logic [31:0] y);
		logic [47:0] p;
		logic [9:0] e;
		logic [22:0] m;
		p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
		e = {2'b00, x[30:23]} + {2'b00, y[30:23]} - 10'd127;
		if (p[47])
		begin
			m = p[46:24];
			e = e + 10'd1;
		end
		else
			m = p[45:23];
		if (x[30:23] == 8'h00 || y[30:23] == 8'h00 || e[9])
			multiply_pipe = {x[31] ^ y[31], 31'h0000_0000};
		else if (e[8] || e[7:0] == 8'hff)
			multiply_pipe = {x[31] ^ y[31], 8'hff, 23'h00_0000};
		else
			multiply_pipe = {x[31] ^ y[31], e[7:0], m};
	endfunction : multiply_pipe

	// ----------------------------------------------------------------
	// 1.5 - t/2 for t below two, normalised back to a float
	// ----------------------------------------------------------------
	function automatic logic [31:0] half_three_minus(input logic [31:0] t);
		logic [24:0] t_fix;
		logic [24:0] c_fix;
		// t scaled by 2^23; an exponent field above the bias shifts it all out
		t_fix = 25'({1'b1, t[22:0]}) >> (`FP_BIAS - t[30:23]);
		// 1.5 scaled by 2^24, result stays above one half
		c_fix = 25'h180_0000 - t_fix;
		if (c_fix[24])
			half_three_minus = {1'b0, `FP_BIAS, c_fix[23:1]};
		else
			half_three_minus = {1'b0, `FP_ONE_HALF_EXP, c_fix[22:0]};
	endfunction : half_three_minus

	// one newton step z*(3 - b*z*z)/2
	function automatic logic [31:0] nr_step(input logic [31:0] z,
		input logic [31:0] b);
		nr_step = multiply_pipe(z, half_three_minus(multiply_pipe(multiply_pipe(z, z), b)));
	endfunction : nr_step

	// ----------------------------------------------------------------
	// rsqrt estimate: linear seed from the bit pattern, three steps
	// ----------------------------------------------------------------
	logic [31:0] b_abs; // sign dropped, estimate is for the magnitude
	logic [31:0] seed; // exponent halved and negated by subtraction
	logic [31:0] z_one; // after the first step
	logic [31:0] z_two; // after the second step
	assign b_abs = {1'b0, i_b[30:0]};
	assign seed = `RSQ_SEED_K - {2'b00, i_b[30:1]};
	assign z_one = nr_step(seed, b_abs);
	assign z_two = nr_step(z_one, b_abs);
	// seed is a few bits good, three steps reach well past fifteen
	assign o_rsqrt = nr_step(z_two, b_abs);

	// ----------------------------------------------------------------
	// refine pieces: step1 b*z^2 then final z*(3-t)/2
	// ----------------------------------------------------------------
	assign o_refine = multiply_pipe(i_a, i_b);
	assign o_final = multiply_pipe(half_three_minus(i_a), i_b);
	assign o_mul = multiply_pipe(i_a, i_b);

endmodule : simd_lane_unit

`default_nettype wire

// ### src/simd_math_datapath.sv
// packed 64-bit simd datapath with two issue pipes and fixed latencies
// assumes the decoder serialises dependent operations and holds issue
`default_nettype none
`include "simd_math_defines.svh"

module simd_math_datapath
	import simd_math_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// add pipe issue
	input wire logic i_add_valid,
	input wire simd_issue_s i_add_issue,
	output logic o_add_ready,
	// multiply pipe issue
	input wire logic i_mul_valid,
	input wire simd_issue_s i_mul_issue,
	output logic o_mul_ready,
	// add pipe result
	output logic o_add_done,
	output simd_result_s o_add_result,
	// multiply pipe result
	output logic o_mul_done,
	output simd_result_s o_mul_result
);

	// ----------------------------------------------------------------
	// combinational operation results for one issue
	// ----------------------------------------------------------------
	function automatic logic [31:0] w2f(input logic [15:0] w);
		logic [15:0] mag;
		logic [4:0] lz;
		logic [31:0] sh;
		mag = w[15] ? 16'(-w) : w;
		lz = 5'd0;
		for (int k = 15; k >= 0; k--)
			if (mag[k] && lz == 5'd0 && mag != 16'h0000)
				lz = 5'(16 - k);
		sh = {16'h0000, mag} << (5'd16 + lz);
		if (mag == 16'h0000)
			w2f = 32'h0000_0000;
		else
			w2f = {w[15], 8'(`FP_BIAS + 8'd16 - {3'b000, lz}), sh[31:9]};
	endfunction : w2f

	// two signed word products of one dword, summed and wrapped to 32 bits
	function automatic logic [31:0] madd_pair(input logic [31:0] a,
		input logic [31:0] b);
		logic signed [31:0] p_hi;
		logic signed [31:0] p_lo;
		p_hi = 32'($signed(a[31:16])) * 32'($signed(b[31:16]));
		p_lo = 32'($signed(a[15:0])) * 32'($signed(b[15:0]));
		madd_pair = 32'(p_hi + p_lo);
	endfunction : madd_pair

	// ----------------------------------------------------------------
	// per pipe state: one operation in flight, counted down
	// ----------------------------------------------------------------
	typedef enum {ST_IDLE, ST_BUSY} pipe_state_e;

	logic [63:0] res_add;
	logic [63:0] res_mul;
	logic [3:0] lat_add;
	logic [3:0] lat_mul;

	// result and latency for each pipe from its issue bundle
	for (genvar p = 0; p < 2; p++)
	begin : g_pipe
		simd_issue_s iss;
		logic [31:0] m_hi, m_lo, r_lo, f_hi, f_lo, q_hi, q_lo;
		logic [63:0] res;
		logic [3:0] lat;
		logic [3:0] base;
		assign iss = (p == 0) ? i_add_issue : i_mul_issue;
		simd_lane_unit u_hi (.i_a(iss.dst[63:32]), .i_b(iss.src[63:32]),
			.o_mul(m_hi), .o_rsqrt(), .o_refine(q_hi),
			.o_final(f_hi));
		simd_lane_unit u_lo (.i_a(iss.dst[31:0]), .i_b(iss.src[31:0]),
			.o_mul(m_lo), .o_rsqrt(r_lo), .o_refine(q_lo),
			.o_final(f_lo));
		// operation select
		always_comb
		begin
			res = iss.src;
			base = `LAT_DEFAULT;
			case (iss.op)
				OP_DWORD_HALF_SWAP:
					res = {iss.src[`LO_MSB:`LO_LSB],
						iss.src[`HI_MSB:`HI_LSB]};
				OP_PACKED_WORD_MUL_ADD:
					res = {madd_pair(iss.dst[63:32], iss.src[63:32]),
						madd_pair(iss.dst[31:0], iss.src[31:0])};
				OP_RSQRT_APPROX:
				begin
					res = {r_lo, r_lo};
					base = `LAT_RSQRT_APPROX;
				end
				OP_RSQRT_REFINE_STEP:
				begin
					res = {q_hi, q_lo};
					base = `LAT_REFINE;
				end
				OP_RECIPROCAL_FINAL_STEP:
				begin
					res = {f_hi, f_lo};
					base = `LAT_REFINE;
				end
				OP_PACKED_FLOAT_MULTIPLY:
				begin
					res = {m_hi, m_lo};
					base = `LAT_MULTIPLY_PIPE;
				end
				OP_PACKED_BITWISE_XOR:
				begin
					res = iss.dst ^ iss.src;
					base = `LAT_XOR + `PEN_BYPASS_IN;
				end
				OP_PACKED_WORD_TO_FLOAT:
					res = {w2f(iss.src[47:32]), w2f(iss.src[15:0])};
				OP_LOW_DWORD_INTERLEAVE:
					res = {iss.src[31:0], iss.dst[31:0]};
				default:
					res = iss.src;
			endcase
		end
		// extra penalty when xor feeds a packed float consumer
		assign lat = base + ((iss.op == OP_PACKED_BITWISE_XOR && iss.to_float)
			? `PEN_TO_FLOAT : 4'h0);
	end

	assign res_add = g_pipe[0].res;
	assign res_mul = g_pipe[1].res;
	assign lat_add = g_pipe[0].lat;
	assign lat_mul = g_pipe[1].lat;

	// ----------------------------------------------------------------
	// add pipe sequencer
	// ----------------------------------------------------------------
	pipe_state_e add_state_reg;
	logic [3:0] add_cnt_reg;
	simd_result_s add_res_reg;
	// xor, copy, interleave, swap accepted on either pipe
	assign o_add_ready = (add_state_reg == ST_IDLE);
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			add_state_reg <= ST_IDLE;
			add_cnt_reg <= 4'h0;
			add_res_reg <= '0;
		end
		else
			case (add_state_reg)
				ST_IDLE:
					if (i_add_valid)
					begin
						add_state_reg <= ST_BUSY;
						add_cnt_reg <= lat_add; // done sampled at edge lat
						add_res_reg <= {i_add_issue.dst_tag, res_add};
					end
				default:
					if (add_cnt_reg == 4'h1)
						add_state_reg <= ST_IDLE;
					else
						add_cnt_reg <= add_cnt_reg - 4'h1;
			endcase
	end
	assign o_add_done = (add_state_reg == ST_BUSY) && (add_cnt_reg == 4'h1);
	assign o_add_result = add_res_reg;

	// ----------------------------------------------------------------
	// multiply pipe sequencer, independent of the add pipe
	// ----------------------------------------------------------------
	pipe_state_e mul_state_reg;
	logic [3:0] mul_cnt_reg;
	simd_result_s mul_res_reg;
	assign o_mul_ready = (mul_state_reg == ST_IDLE);
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mul_state_reg <= ST_IDLE;
			mul_cnt_reg <= 4'h0;
			mul_res_reg <= '0;
		end
		else
			case (mul_state_reg)
				ST_IDLE:
					if (i_mul_valid)
					begin
						mul_state_reg <= ST_BUSY;
						mul_cnt_reg <= lat_mul; // done sampled at edge lat
						mul_res_reg <= {i_mul_issue.dst_tag, res_mul};
					end
				default:
					if (mul_cnt_reg == 4'h1)
						mul_state_reg <= ST_IDLE;
					else
						mul_cnt_reg <= mul_cnt_reg - 4'h1;
			endcase
	end
	assign o_mul_done = (mul_state_reg == ST_BUSY) && (mul_cnt_reg == 4'h1);
	assign o_mul_result = mul_res_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	swap_halves_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_DWORD_HALF_SWAP
		|=> add_res_reg.data == {$past(i_add_issue.src[31:0]),
		$past(i_add_issue.src[63:32])})
		else $error("swap halves wrong");
	multiply_pipe_lat_a: assert property (
		i_mul_valid && o_mul_ready
		&& i_mul_issue.op == OP_PACKED_FLOAT_MULTIPLY |-> ##4 o_mul_done)
		else $error("multiply latency wrong");
	xor_lat_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_PACKED_BITWISE_XOR
		&& !i_add_issue.to_float |-> !o_add_done [*3] ##1 o_add_done)
		else $error("xor latency wrong");
	sign_toggle_a: assert property (
		i_mul_valid && o_mul_ready && i_mul_issue.op == OP_PACKED_BITWISE_XOR
		&& i_mul_issue.src == `SIGN_MASK
		|=> (mul_res_reg.data ^ $past(i_mul_issue.dst)) == `SIGN_MASK)
		else $error("sign toggle wrong");
	interleave_a: assert property (
		i_mul_valid && o_mul_ready && i_mul_issue.op == OP_LOW_DWORD_INTERLEAVE
		|=> mul_res_reg.data == {$past(i_mul_issue.src[31:0]),
		$past(i_mul_issue.dst[31:0])})
		else $error("interleave wrong");
	both_pipes_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_REG_COPY
		&& i_mul_valid && o_mul_ready
		|=> add_res_reg.data == $past(i_add_issue.src) && !o_mul_ready)
		else $error("pipes not parallel");
	xor_either_a: assert property (
		i_mul_valid && o_mul_ready && i_mul_issue.op == OP_PACKED_BITWISE_XOR
		|=> mul_res_reg.data == ($past(i_mul_issue.dst)
		^ $past(i_mul_issue.src)))
		else $error("xor blocked on pipe");
	madd_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_PACKED_WORD_MUL_ADD
		&& i_add_issue.dst[63:16] == 48'h0000_0000_0000
		&& i_add_issue.dst[15:0] == 16'h0002
		|=> add_res_reg.data[31:0]
		== 32'($signed($past(i_add_issue.src[15:0])) * 2))
		else $error("multiply add wrong");
	refine_lat_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_RSQRT_REFINE_STEP
		|-> ##4 o_add_done) else $error("refine latency wrong");
	rsqrt_lat_a: assert property (
		i_add_valid && o_add_ready && i_add_issue.op == OP_RSQRT_APPROX
		|-> ##3 o_add_done) else $error("estimate latency wrong");

	cover_xor_both: cover property (i_add_valid && o_add_ready
		&& i_mul_valid && o_mul_ready
		&& i_add_issue.op == OP_PACKED_BITWISE_XOR
		&& i_mul_issue.op == OP_PACKED_BITWISE_XOR);
	cover_copy_il: cover property (i_add_valid && o_add_ready
		&& i_add_issue.op == OP_REG_COPY && i_mul_valid && o_mul_ready
		&& i_mul_issue.op == OP_LOW_DWORD_INTERLEAVE);
	cover_multiply_pipe: cover property (o_mul_done);

endmodule : simd_math_datapath

`default_nettype wire

// ### verif/simd_issue_model.sv
// decoder-side issue model for one pipe of the simd math datapath
// assumes one run() call at a time per instance, inputs on core clock
`default_nettype none

module simd_issue_model
	import simd_math_pkg::*;
(
	// clock
	input wire logic i_core_clk,
	// pipe handshake and result
	input wire logic i_ready,
	input wire logic i_done,
	input wire simd_result_s i_result,
	// issue request
	output logic o_valid,
	output simd_issue_s o_issue
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle request at time zero
	initial
	begin
		o_valid = 1'b0;
		o_issue = '0;
	end

	// hold request until an edge sees ready, then count edges to done
	task automatic run(input simd_issue_s x, output simd_result_s r,
		output int n);
		int k;
		@(posedge i_core_clk);
		#1;
		o_valid = 1'b1;
		o_issue = x;
		k = 0;
		while (i_ready !== 1'b1 && k < 50)
		begin
			@(posedge i_core_clk);
			#1;
			k++;
		end
		@(posedge i_core_clk);
		#1;
		o_valid = 1'b0;
		o_issue = ~x; // released fields never show the old value
		// done seen after edge n-1 is sampled by the pipe at edge n
		n = 1;
		while (i_done !== 1'b1 && n < 50)
		begin
			@(posedge i_core_clk);
			#1;
			n++;
		end
		r = i_result;
	endtask : run
endmodule : simd_issue_model

`default_nettype wire

// ### verif/packed_simd_math_datapath_tb.sv
// self-checking bench for the packed simd math datapath
// assumes one issue model per pipe and inputs moved 1 ns after edges
`default_nettype none

module packed_simd_math_datapath_tb
	import simd_math_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic add_valid, mul_valid, add_ready, mul_ready, add_done, mul_done;
	simd_issue_s add_issue, mul_issue;
	simd_result_s add_result, mul_result;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	localparam logic [63:0] HALF2 = 64'h3f00_0000_3f00_0000;
	localparam logic [63:0] TWO2 = 64'h4000_0000_4000_0000;
	localparam logic [63:0] MASK = 64'h8000_0000_8000_0000;

	always #10 i_core_clk = ~i_core_clk;

	simd_math_datapath simd_math_datapath_i (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_add_valid(add_valid), .i_add_issue(add_issue),
		.o_add_ready(add_ready), .i_mul_valid(mul_valid),
		.i_mul_issue(mul_issue), .o_mul_ready(mul_ready),
		.o_add_done(add_done), .o_add_result(add_result),
		.o_mul_done(mul_done), .o_mul_result(mul_result));
	simd_issue_model add_model (.i_core_clk(i_core_clk),
		.i_ready(add_ready), .i_done(add_done), .i_result(add_result),
		.o_valid(add_valid), .o_issue(add_issue));
	simd_issue_model mul_model (.i_core_clk(i_core_clk),
		.i_ready(mul_ready), .i_done(mul_done), .i_result(mul_result),
		.o_valid(mul_valid), .o_issue(mul_issue));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic chk64(string what, logic [63:0] exp, logic [63:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk64

	task automatic chk_lat(string what, int exp, int got);
		check_count++;
		if (got != exp)
		begin
			num_errors++;
			$display("unexpected %s latency: expected %0d seen %0d",
				what, exp, got);
		end
	endtask : chk_lat

	// both float lanes within tol units of the last place
	task automatic chk_ulp(string what, logic [63:0] exp, logic [63:0] got,
		int tol);
		int dh;
		int dl;
		check_count++;
		dh = int'(got[63:32]) - int'(exp[63:32]);
		dl = int'(got[31:0]) - int'(exp[31:0]);
		if ($isunknown(got) || dh > tol || -dh > tol || dl > tol || -dl > tol)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk_ulp

	// one issue on a pipe with latency and tag checked
	task automatic go(pipe_sel_e p, simd_op_e op, logic tf, logic [63:0] d,
		logic [63:0] s, int lat, output logic [63:0] res);
		simd_issue_s x;
		simd_result_s r;
		int n;
		x = '{op, p, tf, 3'(op), d, s};
		if (p == PIPE_ADD)
			add_model.run(x, r, n);
		else
			mul_model.run(x, r, n);
		chk_lat(op.name(), lat, n);
		chk64("result tag", {61'h0, 3'(op)}, {61'h0, r.dst_tag});
		res = r.data;
	endtask : go

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_swap_mul_add();
		logic [63:0] v;
		go(PIPE_ADD, OP_DWORD_HALF_SWAP, 1'b0, '0,
			64'h1111_2222_3333_4444, 2, v);
		chk64("swap", 64'h3333_4444_1111_2222, v);
		go(PIPE_MUL, OP_PACKED_WORD_MUL_ADD, 1'b0, 64'h0001_fffe_0003_fffc,
			64'h0005_0006_fff9_0008, 2, v);
		chk64("mul add", 64'hffff_fff9_ffff_ffcb, v);
		go(PIPE_MUL, OP_PACKED_WORD_MUL_ADD, 1'b0, 64'h8000_8000_8000_8000,
			64'h8000_8000_8000_8000, 2, v);
		chk64("mul add wrap", MASK, v);
		go(PIPE_ADD, OP_PACKED_WORD_MUL_ADD, 1'b0, 64'h0000_0000_0000_0002,
			64'h0000_0000_0000_fffd, 2, v);
		chk64("mul add single", 64'h0000_0000_ffff_fffa, v);
	endtask : t_swap_mul_add

	// sign toggle on both pipes at once, plain and into float
	task automatic t_xor_both_pipes();
		logic [63:0] a;
		logic [63:0] b;
		fork
			go(PIPE_ADD, OP_PACKED_BITWISE_XOR, 1'b0,
				64'h3f80_0000_c000_0000, MASK, 3, a);
			go(PIPE_MUL, OP_PACKED_BITWISE_XOR, 1'b1,
				64'h0000_0001_8040_0000, MASK, 4, b);
		join
		chk64("xor add pipe", 64'hbf80_0000_4000_0000, a);
		chk64("xor mul pipe", 64'h8000_0001_0040_0000, b);
	endtask : t_xor_both_pipes

	task automatic t_multiply_pipe_convert();
		logic [63:0] v;
		go(PIPE_MUL, OP_PACKED_FLOAT_MULTIPLY, 1'b0, 64'hbfc0_0000_4000_0000,
			64'h4000_0000_4040_0000, 4, v);
		chk64("multiply_pipe", 64'hc040_0000_40c0_0000, v);
		go(PIPE_ADD, OP_PACKED_WORD_TO_FLOAT, 1'b0, '0,
			64'h1234_fffe_abcd_0005, 2, v);
		chk64("word to float", 64'hc000_0000_40a0_0000, v);
	endtask : t_multiply_pipe_convert

	// independent interleave and copy side by side
	task automatic t_interleave_copy();
		logic [63:0] a;
		logic [63:0] b;
		fork
			go(PIPE_MUL, OP_LOW_DWORD_INTERLEAVE, 1'b0, 64'haaaa_aaaa_1111_1111,
				64'hbbbb_bbbb_2222_2222, 2, a);
			go(PIPE_ADD, OP_REG_COPY, 1'b0, '0,
				64'h0123_4567_89ab_cdef, 2, b);
		join
		chk64("interleave", 64'h2222_2222_1111_1111, a);
		chk64("copy", 64'h0123_4567_89ab_cdef, b);
	endtask : t_interleave_copy

	// chained sqrt of 4.0: step latencies sum to 7, 19 and 23
	task automatic t_sqrt_chain();
		logic [63:0] aa;
		logic [63:0] z;
		logic [63:0] q;
		logic [63:0] t;
		aa = 64'h4080_0000_4080_0000;
		go(PIPE_ADD, OP_RSQRT_APPROX, 1'b0, '0, {32'h0, aa[31:0]}, 3,
			z);
		chk_ulp("rsqrt approx", HALF2, z, 512);
		go(PIPE_MUL, OP_PACKED_FLOAT_MULTIPLY, 1'b0, z, aa, 4, q);
		chk_ulp("fast sqrt", TWO2, q, 512);
		go(PIPE_MUL, OP_PACKED_FLOAT_MULTIPLY, 1'b0, z, z, 4, q);
		go(PIPE_ADD, OP_RSQRT_REFINE_STEP, 1'b0, q, aa, 4, t);
		go(PIPE_ADD, OP_RECIPROCAL_FINAL_STEP, 1'b0, t, z, 4, z);
		chk_ulp("rsqrt refined", HALF2, z, 1);
		go(PIPE_MUL, OP_PACKED_FLOAT_MULTIPLY, 1'b0, z, aa, 4, q);
		chk_ulp("sqrt", TWO2, q, 2);
	endtask : t_sqrt_chain

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			complete_run();
		end
	end

	initial
	begin
		repeat (12) @(posedge i_core_clk);
		chk64("reset ready", 64'h3, {62'h0, add_ready, mul_ready});
		chk64("reset done", 64'h0, {62'h0, add_done, mul_done});
		#1;
		i_rst_n = 1'b1;
		t_swap_mul_add();
		t_xor_both_pipes();
		t_multiply_pipe_convert();
		t_interleave_copy();
		t_sqrt_chain();
		complete_run();
	end
endmodule : packed_simd_math_datapath_tb

`default_nettype wire
